/* File: common/plc_pkg.sv */
package plc_pkg;

	// Device clock and strobe timing
	localparam int CLK_MHZ = 100;
	localparam int STROBE_US = 1300;
	localparam int STROBE_CYC = STROBE_US * CLK_MHZ;

	// Line supervision delays, as least times
	localparam int CONNECT_DELAY_US = 80000;
	localparam int DISCONNECT_DELAY_US = 1300000;
	localparam int CONNECT_STROBES = (CONNECT_DELAY_US + STROBE_US - 1) / STROBE_US;
	localparam int DISCONNECT_STROBES = (DISCONNECT_DELAY_US + STROBE_US - 1) / STROBE_US;

	// Bus geometry
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	localparam int CNT_W = 16;
	localparam int DIV_W = 32;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
	localparam logic [ADDR_W-1:0] REG_TIMERS = 4'h8;

	// Control register fields
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_STOP_BIT = 1;
	localparam logic [1:0] CTRL_RESET = 2'h0;

	// Status register fields
	localparam int STAT_STATE_LSB = 0;
	localparam int STAT_RX_BIT = 4;
	localparam int STAT_PAPER_BIT = 5;
	localparam int STAT_TX_BIT = 6;
	localparam int STAT_SEL_BIT = 7;

	// Synchroniser lanes
	localparam int SYN_RX = 0;
	localparam int SYN_START = 1;
	localparam int SYN_STOP = 2;
	localparam int SYN_PAPER = 3;
	localparam int SYN_DIAL = 4;
	localparam int SYN_DIST = 5;
	localparam int SYN_W = 6;

	// Call supervision states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_REQUEST,
		ST_DIAL,
		ST_CONNECT,
		ST_STOPPING
	} plc_state_e;

endpackage

/* File: design/plc_call_ctrl.sv */
`timescale 1ns/1ps
// Summary of operation
// - From idle, holding start drives the sending leg marking to request a call.
// - Go-ahead mark enters proceed-to-dial, lights dial lamp, energises dial latch relay.
// - Short receive marks never connect; any space restarts connect timing.
// - In proceed-to-dial, dial make and break go out as mark and space.
// - Receive mark held for connect delay connects at next strobe; relay, lamp, motor on.
// - While connected the distributor drives the sending leg and local selector.
// - While connected received signals reach the selector without touching sending.
// - Receive space held for disconnect delay drops connect at next strobe.
// - Sustained incoming mark from idle connects and hands the sending leg to the distributor.
// - Low paper blocks new connections; a connected call may finish.
// - Stop while connected spaces the sending leg and holds it through disconnect.
// - Leaving connect blinds the selector spacing and returns to idle.
// - Idle keeps sending leg spacing and all call outputs inactive.
module plc_call_ctrl #(
	parameter int STROBE_CYC = plc_pkg::STROBE_CYC,
	parameter int CONNECTED_LAMP_STROBES = plc_pkg::CONNECT_STROBES,
	parameter int DISC_STROBES = plc_pkg::DISCONNECT_STROBES
) (
	// Clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Operator and machine inputs
	input wire logic start_btn_i,
	input wire logic stop_btn_i,
	input wire logic dial_make_i,
	input wire logic distributor_i,
	input wire logic low_paper_i,
	// Polar line
	input wire logic rx_leg_i,
	output logic tx_leg_o,
	// Local drivers and lamps
	output logic selector_o,
	output logic dial_lamp_o,
	output logic dial_latch_relay_o,
	output logic connected_lamp_o,
	output logic connect_relay_o,
	output logic loop_transfer_contacts_o,
	output logic motor_o,
	// Avalon-MM slave
	input wire logic [plc_pkg::ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [plc_pkg::DATA_W-1:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [plc_pkg::DATA_W-1:0] avs_readdata_o,
	output logic avs_waitrequest_o
);
	import plc_pkg::*;

	logic [SYN_W-1:0] sync1, sync2, next_sync1, next_sync2;
	logic [DIV_W-1:0] div_cnt, next_div_cnt;
	logic strobe, next_strobe;
	logic [CNT_W-1:0] connected_lamp_cnt, next_connected_lamp_cnt, disc_cnt, next_disc_cnt;
	logic connected_lamp_fire, disc_fire;
	logic rx_mark, paper_low, start_req, stop_req;
	plc_state_e state, next_state;
	logic next_tx, next_sel, next_dial, next_connected_lamp;
	logic [1:0] ctrl, next_ctrl;
	logic [DATA_W-1:0] next_rdata;
	logic next_wait;

	// Two-stage synchronisers for all external levels
	always_comb begin
		next_sync1 = sync1;
		next_sync1[SYN_RX] = rx_leg_i;
		next_sync1[SYN_START] = start_btn_i;
		next_sync1[SYN_STOP] = stop_btn_i;
		next_sync1[SYN_PAPER] = low_paper_i;
		next_sync1[SYN_DIAL] = dial_make_i;
		next_sync1[SYN_DIST] = distributor_i;
		next_sync2 = sync1;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1 <= '0;
			sync2 <= '0;
		end else if (ce_i) begin
			sync1 <= next_sync1;
			sync2 <= next_sync2;
		end
	end

	// Qualified levels from the second stage only
	assign rx_mark = sync2[SYN_RX];
	assign paper_low = sync2[SYN_PAPER];
	assign start_req = sync2[SYN_START] | ctrl[CTRL_START_BIT];
	assign stop_req = sync2[SYN_STOP] | ctrl[CTRL_STOP_BIT];

	// Periodic sampling strobe
	always_comb begin
		next_strobe = 1'b0;
		if (div_cnt == DIV_W'(STROBE_CYC - 1)) begin
			next_div_cnt = '0;
			next_strobe = 1'b1;
		end else begin
			next_div_cnt = div_cnt + 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div_cnt <= '0;
			strobe <= 1'b0;
		end else if (ce_i) begin
			div_cnt <= next_div_cnt;
			strobe <= next_strobe;
		end
	end

	// Connect and disconnect timers count strobes of a steady level
	always_comb begin
		next_connected_lamp_cnt = connected_lamp_cnt;
		next_disc_cnt = disc_cnt;
		if (!rx_mark || paper_low) begin
			next_connected_lamp_cnt = '0;
		end else if (strobe && connected_lamp_cnt != CNT_W'(CONNECTED_LAMP_STROBES)) begin
			next_connected_lamp_cnt = connected_lamp_cnt + 1'b1;
		end
		if (rx_mark) begin
			next_disc_cnt = '0;
		end else if (strobe && disc_cnt != CNT_W'(DISC_STROBES)) begin
			next_disc_cnt = disc_cnt + 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			connected_lamp_cnt <= '0;
			disc_cnt <= '0;
		end else if (ce_i) begin
			connected_lamp_cnt <= next_connected_lamp_cnt;
			disc_cnt <= next_disc_cnt;
		end
	end

	// Delay elapsed; act on the following strobe
	assign connected_lamp_fire = strobe && rx_mark && !paper_low && connected_lamp_cnt == CNT_W'(CONNECTED_LAMP_STROBES);
	assign disc_fire = strobe && !rx_mark && disc_cnt == CNT_W'(DISC_STROBES);

	// Call supervision sequencer
	always_comb begin
		next_state = state;
		unique case (state)
			ST_IDLE: begin
				if (connected_lamp_fire) begin
					next_state = ST_CONNECT;
				end else if (start_req) begin
					next_state = ST_REQUEST;
				end
			end
			ST_REQUEST: begin
				if (rx_mark) begin
					next_state = ST_DIAL;
				end else if (!start_req) begin
					next_state = ST_IDLE;
				end
			end
			ST_DIAL: begin
				if (connected_lamp_fire) begin
					next_state = ST_CONNECT;
				end else if (stop_req) begin
					next_state = ST_IDLE;
				end
			end
			ST_CONNECT: begin
				if (disc_fire) begin
					next_state = ST_IDLE;
				end else if (stop_req) begin
					next_state = ST_STOPPING;
				end
			end
			ST_STOPPING: begin
				if (disc_fire) begin
					next_state = ST_IDLE;
				end
			end
		endcase
	end

	// Line and driver levels for the coming state
	always_comb begin
		next_tx = 1'b0;
		next_sel = 1'b0;
		next_dial = 1'b0;
		next_connected_lamp = 1'b0;
		unique case (next_state)
			ST_IDLE: begin
				next_tx = 1'b0;
			end
			ST_REQUEST: begin
				next_tx = 1'b1;
			end
			ST_DIAL: begin
				next_tx = sync2[SYN_DIAL];
				next_dial = 1'b1;
			end
			ST_CONNECT: begin
				next_tx = sync2[SYN_DIST];
				next_sel = sync2[SYN_DIST] & rx_mark;
				next_connected_lamp = 1'b1;
			end
			ST_STOPPING: begin
				next_tx = 1'b0;
				next_connected_lamp = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= ST_IDLE;
			tx_leg_o <= 1'b0;
			selector_o <= 1'b0;
			dial_lamp_o <= 1'b0;
			dial_latch_relay_o <= 1'b0;
			connected_lamp_o <= 1'b0;
			connect_relay_o <= 1'b0;
			loop_transfer_contacts_o <= 1'b0;
			motor_o <= 1'b0;
		end else if (ce_i) begin
			state <= next_state;
			tx_leg_o <= next_tx;
			selector_o <= next_sel;
			dial_lamp_o <= next_dial;
			dial_latch_relay_o <= next_dial;
			connected_lamp_o <= next_connected_lamp;
			connect_relay_o <= next_connected_lamp;
			loop_transfer_contacts_o <= next_connected_lamp;
			motor_o <= next_connected_lamp;
		end
	end

	// Bus slave: one wait cycle, then answer
	always_comb begin
		next_wait = 1'b1;
		next_rdata = avs_readdata_o;
		next_ctrl = ctrl;
		if ((avs_read_i || avs_write_i) && avs_waitrequest_o) begin
			next_wait = 1'b0;
		end
		if (avs_read_i && avs_waitrequest_o) begin
			next_rdata = '0;
			unique case (avs_address_i)
				REG_CTRL: begin
					next_rdata[1:0] = ctrl;
				end
				REG_STATUS: begin
					next_rdata[STAT_STATE_LSB +: 3] = 3'(state);
					next_rdata[STAT_RX_BIT] = rx_mark;
					next_rdata[STAT_PAPER_BIT] = paper_low;
					next_rdata[STAT_TX_BIT] = tx_leg_o;
					next_rdata[STAT_SEL_BIT] = selector_o;
				end
				REG_TIMERS: begin
					next_rdata = {disc_cnt, connected_lamp_cnt};
				end
				default: begin
					next_rdata = '0;
				end
			endcase
		end
		// Write commits at the edge that sees waitrequest low
		if (avs_write_i && !avs_waitrequest_o && avs_address_i == REG_CTRL && avs_byteenable_i[0]) begin
			next_ctrl = avs_writedata_i[1:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o <= '0;
			ctrl <= CTRL_RESET;
		end else if (ce_i) begin
			avs_waitrequest_o <= next_wait;
			avs_readdata_o <= next_rdata;
			ctrl <= next_ctrl;
		end
	end

endmodule

/* File: verif/plc_call_ctrl_props.sv */
`timescale 1ns/1ps
module plc_call_ctrl_props #(
	parameter int STROBE_CYC = 4,
	parameter int CONNECTED_LAMP_STROBES = 3,
	parameter int DISC_STROBES = 10
) (
	// Watched ports
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic start_btn_i,
	input wire logic stop_btn_i,
	input wire logic distributor_i,
	input wire logic low_paper_i,
	input wire logic rx_leg_i,
	input wire logic tx_leg_o,
	input wire logic selector_o,
	input wire logic dial_lamp_o,
	input wire logic connected_lamp_o,
	input wire logic connect_relay_o,
	input wire logic motor_o
);
	localparam int CONNECTED_LAMP_CYC = CONNECTED_LAMP_STROBES * STROBE_CYC;
	localparam int DISC_CYC = DISC_STROBES * STROBE_CYC;
	localparam int CONNECTED_LAMP_DUE = CONNECTED_LAMP_CYC + 2 * STROBE_CYC + 4;
	localparam int DISC_DUE = DISC_CYC + 2 * STROBE_CYC + 4;
	int mark_run;
	int space_run;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Run lengths of the receiving leg; mark run cleared by low paper
	always_ff @(posedge clk_i) begin
		mark_run <= (rst_i || !rx_leg_i || low_paper_i) ? 0 : mark_run + 1;
		space_run <= (rst_i || rx_leg_i) ? 0 : space_run + 1;
	end
	a_connected_lamp_outputs: assert property (connected_lamp_o |-> connect_relay_o && motor_o && !dial_lamp_o)
		else $error("connect outputs wrong");
	a_connected_lamp_early: assert property ($rose(connected_lamp_o) |-> mark_run >= CONNECTED_LAMP_CYC)
		else $error("connect too early");
	a_connected_lamp_due: assert property (mark_run == CONNECTED_LAMP_DUE |-> connected_lamp_o)
		else $error("connect missing");
	a_disc_early: assert property ($fell(connected_lamp_o) |-> space_run >= DISC_CYC)
		else $error("disconnect too early");
	a_disc_due: assert property (space_run == DISC_DUE |-> !connected_lamp_o)
		else $error("disconnect missing");
	a_blind_exit: assert property ($fell(connected_lamp_o) |-> !selector_o && !tx_leg_o)
		else $error("selector not blinded");
	a_stop_space: assert property ((connected_lamp_o && stop_btn_i)[*4] |-> !tx_leg_o)
		else $error("stop not spacing");
	a_connected_lamp_copy: assert property ((connected_lamp_o && !stop_btn_i && rx_leg_i && distributor_i)[*4]
		|-> tx_leg_o && selector_o)
		else $error("distributor not copied");
	a_idle_quiet: assert property ((!start_btn_i && !connected_lamp_o && !dial_lamp_o)[*5]
		|-> !tx_leg_o && !selector_o && !motor_o)
		else $error("idle outputs active");
endmodule
bind plc_call_ctrl plc_call_ctrl_props #(.STROBE_CYC(STROBE_CYC), .CONNECTED_LAMP_STROBES(CONNECTED_LAMP_STROBES),
	.DISC_STROBES(DISC_STROBES)) plc_call_ctrl_props_i (.*);

/* File: verif/plc_exchange.sv */
`timescale 1ns/1ps
module plc_exchange (
	// Clock and bench control
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ring_i,
	input wire logic hang_i,
	// Polar line
	input wire logic tx_leg_i,
	output logic rx_leg_o
);
	logic [1:0] st;
	int t;
	// Call progress: 0 idle, 1 go-ahead pulse, 2 dialing, 3 connected
	always_ff @(posedge clk_i) begin
		t <= t + 1;
		if (rst_i) begin
			st <= 2'h0;
			t <= 0;
		end else case (st)
			2'h0: if (ring_i) begin
				st <= 2'h3;
				t <= 0;
			end else if (hang_i || !tx_leg_i) t <= 0;
			else if (t == 8) begin
				st <= 2'h1;
				t <= 0;
			end
			2'h1: if (t == 3) st <= 2'h2;
			2'h2: if (t == 64) st <= 2'h3;
			default: if (hang_i || t == 40) st <= 2'h0;
			else if (tx_leg_i) t <= 0;
		endcase
	end
	// Mark in pulse and connected states
	assign rx_leg_o = st[0];
endmodule

/* File: verif/test_plc_call_ctrl.sv */
`timescale 1ns/1ps
module test_plc_call_ctrl;
	import plc_pkg::*;
	// Stimulus and observed signals
	logic clk_i = 0, rst_i = 1, start_btn_i = 0, stop_btn_i = 0, dial_make_i = 1, distributor_i = 1;
	logic low_paper_i = 0, ring = 0, hang = 0, rd = 0, wr = 0, wq, rx_leg;
	logic tx_leg_o, selector_o, dial_lamp_o, connected_lamp_o, motor_o;
	logic [3:0] addr = 4'h0;
	logic [31:0] wd = 32'h0, rdat, q;
	int failures = 0, comparisons = 0;
	always #5 clk_i = ~clk_i;
	plc_call_ctrl #(.STROBE_CYC(4), .CONNECTED_LAMP_STROBES(3), .DISC_STROBES(10)) plc_call_ctrl_i (.clk_i, .rst_i,
		.ce_i(1'b1), .start_btn_i, .stop_btn_i, .dial_make_i, .distributor_i, .low_paper_i,
		.rx_leg_i(rx_leg), .tx_leg_o, .selector_o, .dial_lamp_o, .dial_latch_relay_o(),
		.connected_lamp_o, .connect_relay_o(), .loop_transfer_contacts_o(), .motor_o,
		.avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
		.avs_byteenable_i(4'hf), .avs_readdata_o(rdat), .avs_waitrequest_o(wq));
	plc_exchange plc_exchange_i (.clk_i, .rst_i, .ring_i(ring), .hang_i(hang), .tx_leg_i(tx_leg_o),
		.rx_leg_o(rx_leg));
	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// One bus access, held until waitrequest is seen low
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		addr <= a;
		wd <= d;
		wr <= w;
		rd <= !w;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wq !== 1'b0 && n < 50);
		// No answer in time counts as a mismatch and ends the run
		if (wq !== 1'b0) begin
			failures++;
			results;
		end
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic wait_for(ref logic s, input logic v);
		int n = 0;
		while (s !== v && n < 400) begin
			@(posedge clk_i);
			n++;
		end
		// Level never reached counts as a mismatch and ends the run
		if (s !== v) begin
			failures++;
			results;
		end
	endtask
	task t_regs;
		bus(1'b0, REG_STATUS, 32'h0);
		chk(q, 32'h0);
		// Idle space long enough for the disconnect count to saturate
		repeat (50) @(posedge clk_i);
		bus(1'b0, REG_TIMERS, 32'h0);
		chk(q, 32'h000a0000);
		bus(1'b1, REG_CTRL, 32'h2);
		bus(1'b0, REG_CTRL, 32'h0);
		chk(q, 32'h2);
		bus(1'b1, REG_CTRL, 32'h0);
		bus(1'b0, 4'hc, 32'h0);
		chk(q, 32'h0);
	endtask
	task t_call;
		start_btn_i <= 1'b1;
		wait_for(tx_leg_o, 1'b1);
		chk(dial_lamp_o, 1'b0);
		wait_for(dial_lamp_o, 1'b1);
		chk(connected_lamp_o, 1'b0);
		start_btn_i <= 1'b0;
		dial_make_i <= 1'b0;
		repeat (6) @(posedge clk_i);
		chk({dial_lamp_o, tx_leg_o}, 32'h2);
		dial_make_i <= 1'b1;
		wait_for(connected_lamp_o, 1'b1);
		chk({dial_lamp_o, motor_o, tx_leg_o}, 32'h3);
		bus(1'b0, REG_STATUS, 32'h0);
		chk(q[2:0], 32'h3);
		distributor_i <= 1'b0;
		repeat (6) @(posedge clk_i);
		chk({tx_leg_o, selector_o}, 32'h0);
		distributor_i <= 1'b1;
		stop_btn_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		chk(tx_leg_o, 1'b0);
		wait_for(connected_lamp_o, 1'b0);
		chk({connected_lamp_o, selector_o, tx_leg_o}, 32'h0);
		stop_btn_i <= 1'b0;
	endtask
	task t_incoming;
		ring <= 1'b1;
		wait_for(connected_lamp_o, 1'b1);
		ring <= 1'b0;
		repeat (6) @(posedge clk_i);
		chk({connected_lamp_o, tx_leg_o}, 32'h3);
		low_paper_i <= 1'b1;
		repeat (30) @(posedge clk_i);
		chk(connected_lamp_o, 1'b1);
		hang <= 1'b1;
		wait_for(connected_lamp_o, 1'b0);
		chk({connected_lamp_o, selector_o}, 32'h0);
		hang <= 1'b0;
		ring <= 1'b1;
		@(posedge clk_i);
		ring <= 1'b0;
		repeat (100) @(posedge clk_i);
		chk({connected_lamp_o, tx_leg_o}, 32'h0);
		low_paper_i <= 1'b0;
	endtask
	task results;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs;
		t_call;
		t_incoming;
		results;
	end
	// Watchdog
	initial begin
		repeat (20000) @(posedge clk_i);
		failures++;
		results;
	end
endmodule
